//--- rtl/sslc_map.svh
`ifndef SSLC_MAP_SVH
`define SSLC_MAP_SVH

// Word and latch select layout
`define SSLC_WORD_W        24
`define SSLC_SEL_CTRL      2'h0
`define SSLC_SEL_REF       2'h1
`define SSLC_SEL_FB        2'h2
`define SSLC_SEL_TEST      2'h3

// Control latch fields
`define SSLC_CTL_CLEAR_BIT 4
`define SSLC_CTL_MON_LSB   5
`define SSLC_CTL_CORE_LSB  2
`define SSLC_CTL_GAIN_BIT  10
`define SSLC_CTL_RESET     24'h000000

// Feedback latch fields
`define SSLC_FB_CNT_LSB    8
`define SSLC_FB_GAIN_BIT   21
`define SSLC_FB_MIN        13'h0003
`define SSLC_FB_RESET      13'h0003

// Reference latch fields
`define SSLC_REF_CNT_LSB   2
`define SSLC_REF_ABP_LSB   16
`define SSLC_REF_LDP_BIT   18
`define SSLC_REF_TEST_BIT  19
`define SSLC_REF_BSC_LSB   20
`define SSLC_REF_RESET     14'h0001

// Lock detect: phase window and cycle counts
`define SSLC_LOCK_WIN_NS   15
`define SSLC_CLK_NS        10
`define SSLC_LOCK_WIN_CYC  (`SSLC_LOCK_WIN_NS / `SSLC_CLK_NS)
`define SSLC_LOCK_FINE     3'h5
`define SSLC_LOCK_COARSE   3'h3

// Monitor select codes
`define SSLC_MON_LOW       3'h0
`define SSLC_MON_LOCK      3'h1
`define SSLC_MON_FBDIV     3'h2
`define SSLC_MON_HIGH      3'h3
`define SSLC_MON_REFDIV    3'h4
`define SSLC_MON_BANDCLK   3'h5
`define SSLC_MON_SDATA     3'h6
`define SSLC_MON_GND       3'h7

`endif

//--- rtl/sslc_pkg.sv
package sslc_pkg;

    // Decoded configuration handed to the synthesizer core
    typedef struct packed {
        logic [2:0]  monitor_select_field;
        logic        counter_clear;
        logic [1:0]  core_power_field;
        logic        pump_gain_select;
        logic [12:0] feedback_count;
        logic [13:0] reference_divide_ratio;
        logic [1:0]  backlash_pulse_width;
        logic        lock_precision_bit;
        logic        factory_test_bit;
        logic [1:0]  band_clock_divider;
    } sslc_cfg_t;

    typedef enum logic [1:0] {
        SSLC_LK_HUNT = 2'b01,
        SSLC_LK_LOCK = 2'b10
    } sslc_lock_t;

endpackage : sslc_pkg

//--- rtl/sslc_divider.sv
`timescale 1ns/10ps
`default_nettype none

// Programmable divide-by-N with one-cycle output pulse
module sslc_divider (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clear,
    input  wire logic        tick,
    input  wire logic [13:0] ratio,
    output logic             pulse
);
    logic [13:0] cnt_r;
    logic [13:0] cnt_nxt;
    logic        pulse_r;
    logic        pulse_nxt;

    // ----------------------------------------
    // Count input ticks, wrap at ratio
    // ----------------------------------------
    always_comb begin
        cnt_nxt   = cnt_r;
        pulse_nxt = 1'b0;
        if (clear) begin
            cnt_nxt = 14'h0000;
        end else if (tick) begin
            if (cnt_r + 14'h0001 >= ratio) begin
                cnt_nxt   = 14'h0000;
                pulse_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 14'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= 14'h0000;
            pulse_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign pulse = pulse_r;

endmodule : sslc_divider

`default_nettype wire

//--- rtl/sslc_latch_config.sv
`timescale 1ns/10ps
`default_nettype none
`include "sslc_map.svh"

module sslc_latch_config (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                serial_clk,
    input  wire logic                serial_data,
    input  wire logic                load_strobe,
    input  wire logic                ref_in,
    input  wire logic                osc_in,
    input  wire logic                chip_enable,
    output logic                     monitor_output_pin,
    output logic                     lock_detect,
    output logic                     ref_div_pulse,
    output logic                     fb_div_pulse,
    output logic                     band_clk_pulse,
    output var sslc_pkg::sslc_cfg_t  cfg
);
    import sslc_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Three flops per pin; levels read the second stage, edges the second and third
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [5:0] sync_prev_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // Strobe stages start high: an idle-high strobe gives no false load
            sync1_r     <= 6'h04;
            sync2_r     <= 6'h04;
            sync_prev_r <= 6'h04;
        end else begin
            sync1_r     <= {chip_enable, osc_in, ref_in, load_strobe, serial_data, serial_clk};
            sync2_r     <= sync1_r;
            sync_prev_r <= sync2_r;
        end
    end

    logic sclk_rise;
    logic load_rise;
    logic ref_rise;
    logic osc_rise;
    logic sdata_s;
    logic ce_s;

    assign sclk_rise = sync2_r[0] & ~sync_prev_r[0];
    assign sdata_s   = sync2_r[1];
    assign load_rise = sync2_r[2] & ~sync_prev_r[2];
    assign ref_rise  = sync2_r[3] & ~sync_prev_r[3];
    assign osc_rise  = sync2_r[4] & ~sync_prev_r[4];
    assign ce_s      = sync2_r[5];

    // ----------------------------------------
    // Shift register and latches
    // ----------------------------------------
    logic [23:0] shift_r,  shift_nxt;
    logic [23:0] ctrl_r,   ctrl_nxt;
    logic [23:0] refl_r,   refl_nxt;
    logic [12:0] fbcnt_r,  fbcnt_nxt;
    logic        gain_r,   gain_nxt;

    // Shift stays alive while disabled, as in power-down
    always_comb begin
        shift_nxt = shift_r;
        ctrl_nxt  = ctrl_r;
        refl_nxt  = refl_r;
        fbcnt_nxt = fbcnt_r;
        gain_nxt  = gain_r;
        if (sclk_rise) begin
            shift_nxt = {shift_r[22:0], sdata_s};
        end
        if (load_rise) begin
            case (shift_r[1:0])
                `SSLC_SEL_CTRL: begin
                    ctrl_nxt = shift_r;
                    gain_nxt = shift_r[`SSLC_CTL_GAIN_BIT];
                end
                `SSLC_SEL_REF: begin
                    refl_nxt = shift_r;
                end
                `SSLC_SEL_FB: begin
                    // Below-minimum counts are clamped so the divider never stalls
                    fbcnt_nxt = (shift_r[20:8] < `SSLC_FB_MIN) ? `SSLC_FB_MIN
                                                               : shift_r[20:8];
                    gain_nxt  = shift_r[`SSLC_FB_GAIN_BIT];
                end
                default: begin
                    // Test latch not modelled: contents ignored
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= 24'h000000;
            ctrl_r  <= `SSLC_CTL_RESET;
            refl_r  <= {8'h00, `SSLC_REF_RESET, 2'h1};
            fbcnt_r <= `SSLC_FB_RESET;
            gain_r  <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            ctrl_r  <= ctrl_nxt;
            refl_r  <= refl_nxt;
            fbcnt_r <= fbcnt_nxt;
            gain_r  <= gain_nxt;
        end
    end

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    logic [13:0] ref_ratio;
    logic        ctr_clear;

    // Zero ratio would wrap on every tick; treat it as the minimum of one
    assign ref_ratio = (refl_r[15:2] == 14'h0000) ? 14'h0001 : refl_r[15:2];

    always_comb begin
        cfg.monitor_select_field   = ctrl_r[7:5];
        cfg.counter_clear          = ctrl_r[`SSLC_CTL_CLEAR_BIT];
        cfg.core_power_field       = ctrl_r[3:2];
        cfg.pump_gain_select       = gain_r;
        cfg.feedback_count         = fbcnt_r;
        cfg.reference_divide_ratio = ref_ratio;
        cfg.backlash_pulse_width   = refl_r[17:16];
        cfg.lock_precision_bit     = refl_r[`SSLC_REF_LDP_BIT];
        cfg.factory_test_bit       = refl_r[`SSLC_REF_TEST_BIT];
        cfg.band_clock_divider     = refl_r[21:20];
    end

    // Dividers are held while cleared or while the chip is disabled
    assign ctr_clear = ctrl_r[`SSLC_CTL_CLEAR_BIT] | ~ce_s;

    // ----------------------------------------
    // Reference and feedback dividers
    // ----------------------------------------
    sslc_divider u_ref_div (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clear   (ctr_clear),
        .tick    (ref_rise),
        .ratio   (ref_ratio),
        .pulse   (ref_div_pulse)
    );

    sslc_divider u_fb_div (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clear   (ctr_clear),
        .tick    (osc_rise),
        .ratio   ({1'b0, fbcnt_r}),
        .pulse   (fb_div_pulse)
    );

    // ----------------------------------------
    // Band clock divider
    // ----------------------------------------
    // Code 0 passes the reference output; others divide by 2, 4 or 8
    logic [2:0] band_cnt_r, band_cnt_nxt;
    logic       band_r,     band_nxt;
    logic [2:0] band_mask;

    always_comb begin
        case (refl_r[21:20])
            2'h1:    band_mask = 3'h1;
            2'h2:    band_mask = 3'h3;
            2'h3:    band_mask = 3'h7;
            default: band_mask = 3'h0;
        endcase
        band_cnt_nxt = band_cnt_r;
        band_nxt     = 1'b0;
        if (ctr_clear) begin
            band_cnt_nxt = 3'h0;
        end else if (ref_div_pulse) begin
            band_cnt_nxt = (band_cnt_r + 3'h1) & band_mask;
            band_nxt     = ((band_cnt_r & band_mask) == band_mask);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            band_cnt_r <= 3'h0;
            band_r     <= 1'b0;
        end else begin
            band_cnt_r <= band_cnt_nxt;
            band_r     <= band_nxt;
        end
    end

    assign band_clk_pulse = band_r;

    // ----------------------------------------
    // Lock detect
    // ----------------------------------------
    // Phase error measured as sys cycles between divider pulses
    sslc_lock_t  lk_r,   lk_nxt;
    logic [3:0]  gap_r,  gap_nxt;
    logic        arm_r,  arm_nxt;
    logic [2:0]  good_r, good_nxt;
    logic [2:0]  need;

    // Good-pair counter step, saturating at the top
    function automatic logic [2:0] sat_inc3(input logic [2:0] v);
        sat_inc3 = (v == 3'h7) ? v : v + 3'h1;
    endfunction : sat_inc3

    assign need = refl_r[`SSLC_REF_LDP_BIT] ? `SSLC_LOCK_FINE : `SSLC_LOCK_COARSE;

    always_comb begin
        lk_nxt   = lk_r;
        gap_nxt  = gap_r;
        arm_nxt  = arm_r;
        good_nxt = good_r;
        case (lk_r)
            SSLC_LK_HUNT: begin
                if (good_r >= need) begin
                    lk_nxt = SSLC_LK_LOCK;
                end
            end
            SSLC_LK_LOCK: begin
            end
            default: begin
                lk_nxt = SSLC_LK_HUNT;
            end
        endcase
        // Clear and a bad pair come last so they beat a pending lock step
        if (ctr_clear) begin
            lk_nxt   = SSLC_LK_HUNT;
            arm_nxt  = 1'b0;
            good_nxt = 3'h0;
            gap_nxt  = 4'h0;
        end else if (ref_div_pulse ^ fb_div_pulse) begin
            if (arm_r) begin
                // Second edge of a pair arrived: judge the gap
                arm_nxt = 1'b0;
                if (gap_r <= 4'(`SSLC_LOCK_WIN_CYC)) begin
                    good_nxt = sat_inc3(good_r);
                end else begin
                    good_nxt = 3'h0;
                    lk_nxt   = SSLC_LK_HUNT;
                end
            end else begin
                arm_nxt = 1'b1;
                gap_nxt = 4'h0;
            end
        end else if (ref_div_pulse & fb_div_pulse) begin
            good_nxt = sat_inc3(good_r);
            arm_nxt  = 1'b0;
        end else if (arm_r) begin
            gap_nxt = (gap_r == 4'hF) ? gap_r : gap_r + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lk_r   <= SSLC_LK_HUNT;
            gap_r  <= 4'h0;
            arm_r  <= 1'b0;
            good_r <= 3'h0;
        end else begin
            lk_r   <= lk_nxt;
            gap_r  <= gap_nxt;
            arm_r  <= arm_nxt;
            good_r <= good_nxt;
        end
    end

    assign lock_detect = (lk_r == SSLC_LK_LOCK);

    // ----------------------------------------
    // Monitor output multiplexer
    // ----------------------------------------
    logic mon_nxt, mon_r;

    always_comb begin
        case (ctrl_r[7:5])
            `SSLC_MON_LOCK:    mon_nxt = lock_detect;
            `SSLC_MON_FBDIV:   mon_nxt = fb_div_pulse;
            `SSLC_MON_HIGH:    mon_nxt = 1'b1;
            `SSLC_MON_REFDIV:  mon_nxt = ref_div_pulse;
            `SSLC_MON_BANDCLK: mon_nxt = band_r;
            `SSLC_MON_SDATA:   mon_nxt = sdata_s;
            default:           mon_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mon_r <= 1'b0;
        end else begin
            mon_r <= mon_nxt;
        end
    end

    assign monitor_output_pin = mon_r;

endmodule : sslc_latch_config

`default_nettype wire

//--- bench/sslc_latch_config_chk.sv
`timescale 1ns/10ps
`default_nettype none

// Pin-level checker for the serial load path and dividers
module sslc_latch_config_chk (
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                serial_clk,
    input wire logic                serial_data,
    input wire logic                load_strobe,
    input wire logic                ref_in,
    input wire logic                osc_in,
    input wire logic                chip_enable,
    input wire logic                monitor_output_pin,
    input wire logic                lock_detect,
    input wire logic                ref_div_pulse,
    input wire logic                fb_div_pulse,
    input wire logic                band_clk_pulse,
    input wire sslc_pkg::sslc_cfg_t cfg
);
    import sslc_pkg::*;

    logic       le_q_r;
    logic       le_q_nxt;
    logic [2:0] age_r;
    logic [2:0] age_nxt;

    // ---------------------------------------------
    // Cycles since the strobe pin last rose
    // ---------------------------------------------
    // Saturates so a config change long after any strobe still fails
    always_comb begin
        le_q_nxt = load_strobe;
        age_nxt  = age_r;
        if (load_strobe && !le_q_r) age_nxt = 3'h0;
        else if (age_r != 3'h7) age_nxt = age_r + 3'h1;
    end

    // Register the strobe tracker
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            le_q_r <= 1'b0;
            age_r  <= 3'h7;
        end else begin
            le_q_r <= le_q_nxt;
            age_r  <= age_nxt;
        end
    end

    // ---------------------------------------------
    // Properties
    // ---------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Static monitor sources, once the select has settled
    property p_mon(logic [2:0] code, logic lvl);
        (cfg.monitor_select_field == code && $stable(cfg.monitor_select_field))
            |-> monitor_output_pin == lvl;
    endproperty

    AST_MON_LOW: assert property (p_mon(3'h0, 1'b0)) else $error("monitor not low");
    AST_MON_HIGH: assert property (p_mon(3'h3, 1'b1)) else $error("monitor not high");
    AST_MON_GND: assert property (p_mon(3'h7, 1'b0)) else $error("monitor not low");
    AST_MON_LOCK: assert property ((cfg.monitor_select_field == 3'h1)
        && $stable(cfg.monitor_select_field) && $stable(lock_detect)
        |-> monitor_output_pin == lock_detect) else $error("monitor not lock");
    AST_CLEAR: assert property (cfg.counter_clear [*3]
        |-> !ref_div_pulse && !fb_div_pulse && !lock_detect) else $error("clear ignored");
    AST_CHIP_EN: assert property (!chip_enable [*4]
        |-> !ref_div_pulse && !fb_div_pulse && !lock_detect) else $error("enable ignored");
    AST_FB_MIN: assert property (cfg.feedback_count >= 13'h0003) else $error("count below 3");
    AST_REF_MIN: assert property (cfg.reference_divide_ratio != 14'h0000) else $error("ratio 0");
    AST_CFG_LOAD: assert property ($changed(cfg) |-> age_r <= 3'h6) else $error("load w/o strobe");

    // Main scenarios reached
    COV_LOCK: cover property ($rose(lock_detect));
    COV_LOAD: cover property ($changed(cfg));
    COV_BAND: cover property (band_clk_pulse);
    COV_PAIR: cover property (ref_div_pulse && fb_div_pulse);

endmodule : sslc_latch_config_chk

bind sslc_latch_config sslc_latch_config_chk i_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .serial_clk(serial_clk),
    .serial_data(serial_data), .load_strobe(load_strobe), .ref_in(ref_in),
    .osc_in(osc_in), .chip_enable(chip_enable), .monitor_output_pin(monitor_output_pin),
    .lock_detect(lock_detect), .ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse),
    .band_clk_pulse(band_clk_pulse), .cfg(cfg)
);

`default_nettype wire

//--- bench/sslc_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host serial master: three-wire word writer
module sslc_host_model (
    input  wire logic clk_sys,
    output var logic  serial_clk,
    output var logic  serial_data,
    output var logic  load_strobe
);
    // ---------------------------------------------
    // Idle state: clock parked low, strobe high
    // ---------------------------------------------
    initial begin
        serial_clk  = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b1;
    end

    // Wait n edges, then step just past the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    // One latch write; 60 ns serial period keeps under the rate limit
    task automatic send(input logic [23:0] w);
        int b;
        int i;
        load_strobe = 1'b0;
        for (b = 2; b >= 0; b--) begin
            for (i = 7; i >= 0; i--) begin
                serial_data = w[b*8+i];
                step(3);
                serial_clk = 1'b1;
                step(3);
                serial_clk = 1'b0;
            end
        end
        serial_data = ~serial_data; // Released line must not keep last bit
        load_strobe = 1'b1;
        step(8);
    endtask : send

endmodule : sslc_host_model

`default_nettype wire

//--- bench/synth_serial_latch_config_test.sv
`timescale 1ns/10ps
`default_nettype none

// Scenario bench for the serial latch path
module synth_serial_latch_config_test;
    import sslc_pkg::*;

    logic      clk_sys     = 1'b0;
    logic      rst_n       = 1'b0;
    logic      chip_enable = 1'b1;
    logic [1:0] ph         = 2'h0;
    wire       ref_in      = ph[1];
    wire       osc_in      = ph[1];
    wire       serial_clk;
    wire       serial_data;
    wire       load_strobe;
    logic      monitor_output_pin;
    logic      lock_detect;
    logic      ref_div_pulse;
    logic      fb_div_pulse;
    logic      band_clk_pulse;
    sslc_cfg_t cfg;
    sslc_cfg_t exp_cfg;
    int        fail_count  = 0;
    int        n_checks    = 0;

    // ---------------------------------------------
    // Clock and shared reference/oscillator waveform
    // ---------------------------------------------
    // Same waveform on both inputs so equal ratios give aligned pulses
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) ph <= #1 ph + 2'h1;

    sslc_latch_config i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .serial_clk(serial_clk),
        .serial_data(serial_data), .load_strobe(load_strobe), .ref_in(ref_in),
        .osc_in(osc_in), .chip_enable(chip_enable), .monitor_output_pin(monitor_output_pin),
        .lock_detect(lock_detect), .ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse),
        .band_clk_pulse(band_clk_pulse), .cfg(cfg)
    );

    sslc_host_model i_host (
        .clk_sys(clk_sys), .serial_clk(serial_clk), .serial_data(serial_data),
        .load_strobe(load_strobe)
    );

    // ---------------------------------------------
    // Shared helpers
    // ---------------------------------------------
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic check(input string nm, input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // Count divider pulses over n cycles
    task automatic count(input int n, output int r, output int f, output int b);
        r = 0;
        f = 0;
        b = 0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            if (ref_div_pulse === 1'b1) r++;
            if (fb_div_pulse === 1'b1) f++;
            if (band_clk_pulse === 1'b1) b++;
        end
    endtask : count

    // Latch writes; each compares the whole decoded config
    task automatic wr_ctl(input logic g, input logic [2:0] m, input logic c, input logic [1:0] p);
        i_host.send({13'h0000, g, 2'h0, m, c, p, 2'h0});
        exp_cfg.pump_gain_select = g;
        exp_cfg.monitor_select_field = m;
        exp_cfg.counter_clear = c;
        exp_cfg.core_power_field = p;
        check("ctl cfg", cfg, exp_cfg);
    endtask : wr_ctl

    task automatic wr_ref(input logic [1:0] bs, input logic ld, input logic [1:0] ab,
                          input logic [13:0] r);
        i_host.send({2'h0, bs, 1'b0, ld, ab, r, 2'h1});
        exp_cfg.band_clock_divider = bs;
        exp_cfg.lock_precision_bit = ld;
        exp_cfg.backlash_pulse_width = ab;
        exp_cfg.reference_divide_ratio = r;
        check("ref cfg", cfg, exp_cfg);
    endtask : wr_ref

    task automatic wr_fb(input logic g, input logic [12:0] n);
        i_host.send({2'h0, g, n, 6'h00, 2'h2});
        exp_cfg.pump_gain_select = g;
        exp_cfg.feedback_count = (n < 13'h0003) ? 13'h0003 : n;
        check("fb cfg", cfg, exp_cfg);
    endtask : wr_fb

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    // Latch contents straight after reset
    task automatic t_reset;
        exp_cfg = '0;
        exp_cfg.feedback_count = 13'h0003;
        exp_cfg.reference_divide_ratio = 14'h0001;
        check("reset cfg", cfg, exp_cfg);
    endtask : t_reset

    // Power-up order, field boundaries and clear holding the dividers
    task automatic t_program;
        int r;
        int f;
        int b;
        logic [2:0] mc [3] = '{3'h2, 3'h4, 3'h5};
        wr_ref(2'h2, 1'b1, 2'h3, 14'h3FFF);
        wr_ref(2'h2, 1'b0, 2'h1, 14'h0005);
        wr_ctl(1'b1, 3'h3, 1'b1, 2'h1);
        count(200, r, f, b);
        check("pulses in clear", r + f + b, 0);
        check("monitor high", monitor_output_pin, 1'b1);
        wr_fb(1'b0, 13'h0001);
        wr_fb(1'b1, 13'h0005);
        wr_ctl(1'b0, 3'h4, 1'b0, 2'h1);
        count(400, r, f, b);
        check("ref ratio", r >= 19 && r <= 20, 1'b1);
        check("fb ratio", f >= 19 && f <= 20, 1'b1);
        check("band ratio", b >= 4 && b <= 5, 1'b1);
        // Divider sources on the monitor pin: 160 cycles hold 8 pulses, band 2
        foreach (mc[j]) begin
            wr_ctl(1'b0, mc[j], 1'b0, 2'h1);
            r = 0;
            repeat (160) begin
                @(posedge clk_sys);
                #1;
                if (monitor_output_pin === 1'b1) r++;
            end
            check("monitor divider", r, (mc[j] == 3'h5) ? 2 : 8);
        end
    endtask : t_program

    // Select 11 must leave every latch alone
    task automatic t_test_sel;
        i_host.send(24'hFFFFFF);
        check("test select", cfg, exp_cfg);
    endtask : t_test_sel

    // Aligned pulse pairs needed for lock, both precision settings
    task automatic t_lock;
        int k;
        int n;
        int t;
        for (k = 0; k < 2; k++) begin
            wr_ref(2'h2, k[0], 2'h1, 14'h0005);
            wr_ctl(1'b0, 3'h1, 1'b1, 2'h1);
            wr_ctl(1'b0, 3'h1, 1'b0, 2'h1);
            n = 0;
            for (t = 0; t < 600 && lock_detect !== 1'b1; t++) begin
                @(posedge clk_sys);
                #1;
                if (ref_div_pulse === 1'b1) n++;
            end
            if (t == 600) begin
                fail_count++;
                $display("Error lock wait expected 1 seen 0");
                end_of_test();
            end
            check("lock pairs", n == 3 + 2 * k || n == 2 + 2 * k, 1'b1);
            @(posedge clk_sys);
            #1;
            check("monitor lock", monitor_output_pin, 1'b1);
        end
        chip_enable = 1'b0;
        i_host.step(4);
        check("lock when off", lock_detect, 1'b0);
        chip_enable = 1'b1;
    endtask : t_lock

    // Fixed-level monitor sources
    task automatic t_mon;
        logic [2:0] codes [4] = '{3'h0, 3'h3, 3'h6, 3'h7};
        // Code 6 shows the data line, left high as the inverse of DB0 = 0
        foreach (codes[i]) begin
            wr_ctl(1'b1, codes[i], 1'b0, 2'h2);
            check("monitor level", monitor_output_pin, codes[i] == 3'h3 || codes[i] == 3'h6);
        end
    endtask : t_mon

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        i_host.step(2);
        t_reset();
        t_program();
        t_test_sel();
        t_lock();
        t_mon();
        end_of_test();
    end

endmodule : synth_serial_latch_config_test

`default_nettype wire
